// ==== bcs_defs.vh ====
/*
 * Constants for the battery charge state controller: state codes, target
 * selects and timing counts. Assumes a 250 MHz core clock.
 */
`ifndef BCS_DEFS_VH
`define BCS_DEFS_VH

`define BCS_ST_W 9
`define BCS_ST_DISABLED 9'h001
`define BCS_ST_DEAD 9'h002
`define BCS_ST_DEAD_PQ 9'h004
`define BCS_ST_PREQUAL 9'h008
`define BCS_ST_FC_CC 9'h010
`define BCS_ST_FC_CV 9'h020
`define BCS_ST_TOPOFF 9'h040
`define BCS_ST_DONE 9'h080
`define BCS_ST_FAULT 9'h100

// Current target scale codes.
`define BCS_SCALE_W 2
`define BCS_SCALE_OFF 2'h0
`define BCS_SCALE_HALF 2'h1
`define BCS_SCALE_FULL 2'h2

`define BCS_CLK_MHZ 250
`define BCS_TOPOFF_S 16
// Cycle counts are worked out at timer width; a 32-bit product would wrap.
`define BCS_TOPOFF_CYC (`BCS_TOPOFF_S * `BCS_CLK_MHZ * 42'hF4240)
`define BCS_PQ_MIN 30
`define BCS_PQ_CYC (`BCS_PQ_MIN * 42'h3C * `BCS_CLK_MHZ * 42'hF4240)
`define BCS_FC_MIN 180
`define BCS_FC_CYC (`BCS_FC_MIN * 42'h3C * `BCS_CLK_MHZ * 42'hF4240)
`define BCS_TMR_W 42

`endif

// ==== bcs_sync.v ====
/*
 * Two-flop synchroniser bank for asynchronous comparator flags.
 * Assumes inputs are quasi-static relative to the clock.
 */
`timescale 1ns/10ps
module bcs_sync #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Flags
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge clk) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ==== bcs_charge_ctrl.v ====
/*
 * Charge state sequencer of a single-cell lithium charger. Takes analog
 * comparator flags and drives charger enables and target selects.
 * Assumes all comparator flags and the disable pin are asynchronous.
 */
`timescale 1ns/10ps
`include "bcs_defs.vh"
module bcs_charge_ctrl #(
    parameter [`BCS_TMR_W-1:0] PQ_CYC = `BCS_PQ_CYC,
    parameter [`BCS_TMR_W-1:0] FC_CYC = `BCS_FC_CYC,
    parameter [`BCS_TMR_W-1:0] TOPOFF_CYC = `BCS_TOPOFF_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Pins and supply comparators
    input wire charge_disable_in,
    input wire vin_above_uvlo_rising,
    input wire vin_above_uvlo_falling,
    input wire vin_over_ovlo,
    input wire timer_disable,
    // Battery voltage comparators
    input wire vbat_above_dead_batt,
    input wire vbat_above_dead_batt_upper,
    input wire vbat_above_prequal_upper,
    input wire vbat_at_regulation,
    input wire vbat_below_restart,
    // Charge current comparators
    input wire ibat_below_done,
    input wire ibat_above_done_margin,
    // Thermistor band comparators
    input wire therm_above_cold,
    input wire therm_above_cool,
    input wire therm_above_warm,
    input wire therm_above_hot,
    // Die temperature and program pin checks
    input wire die_above_temp_reg,
    input wire done_pin_shorted,
    input wire done_pin_open,
    // Charger controls
    output reg linear_en,
    output reg switcher_en,
    output reg internal_linear_regulator_en,
    output reg low_power,
    output reg soft_start_en,
    output reg [`BCS_SCALE_W-1:0] prequal_scale,
    output reg [`BCS_SCALE_W-1:0] done_scale,
    output reg [`BCS_SCALE_W-1:0] fast_scale,
    output reg fast_foldback,
    output reg vreg_reduced,
    output reg timer_run,
    output reg [`BCS_ST_W-1:0] state
);
    // Every comparator flag and the disable pin cross into the clock domain
    // through one two-flop bank, so each reaches the sequencer two edges
    // after it changes; the two undervoltage flags take one more edge through vin_ok_q.
    localparam NS = 19;
    wire [NS-1:0] s;

    bcs_sync #(.W(NS)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({charge_disable_in, vin_above_uvlo_rising,
            vin_above_uvlo_falling, vin_over_ovlo, timer_disable,
            vbat_above_dead_batt, vbat_above_dead_batt_upper,
            vbat_above_prequal_upper, vbat_at_regulation,
            vbat_below_restart, ibat_below_done, ibat_above_done_margin,
            therm_above_cold, therm_above_cool, therm_above_warm,
            therm_above_hot, die_above_temp_reg, done_pin_shorted,
            done_pin_open}),
        .sync_out(s)
    );

    wire dis_s = s[18];
    wire uv_rise_s = s[17];
    wire uv_fall_s = s[16];
    wire ovlo_s = s[15];
    wire tmr_off_s = s[14];
    wire vb_dead_s = s[13];
    wire vb_dup_s = s[12];
    wire vb_pq_s = s[11];
    wire vb_reg_s = s[10];
    wire vb_rst_s = s[9];
    wire i_lo_s = s[8];
    wire i_hi_s = s[7];
    wire t_cold_s = s[6];
    wire t_cool_s = s[5];
    wire t_warm_s = s[4];
    wire t_hot_s = s[3];
    wire die_s = s[2];
    wire dn_short_s = s[1];
    wire dn_open_s = s[0];

    // Input supply is valid once above the rising threshold and stays valid
    // down to the falling threshold; a disable toggle re-arms the check.
    reg vin_ok_q;
    reg dis_prev_q;
    reg [`BCS_ST_W-1:0] st_q;
    reg [`BCS_ST_W-1:0] st_d;
    // The timers are 42 bits wide so that the longest fast-charge limit at
    // the core clock rate fits without wrapping.
    reg [`BCS_TMR_W-1:0] pq_tmr_q;
    reg [`BCS_TMR_W-1:0] fc_tmr_q;
    reg [`BCS_TMR_W-1:0] to_tmr_q;
    reg from_done_q;

    wire therm_in_range = t_cold_s & ~t_hot_s;
    wire therm_cool_band = t_cold_s & ~t_cool_s;
    wire therm_full_band = t_cool_s & ~t_hot_s;
    wire charging = st_q[1] | st_q[2] | st_q[3] | st_q[4] | st_q[5] |
        st_q[6];
    // Charger is suspended, timers frozen, outside the thermistor band or
    // above the overvoltage limit.
    wire suspend = ~therm_in_range | ovlo_s;
    wire dis_rise = dis_s & ~dis_prev_q;
    wire enable_ok = ~dis_s & vin_ok_q;
    wire pq_exp = ~tmr_off_s & (pq_tmr_q >= PQ_CYC);
    wire fc_exp = ~tmr_off_s & (fc_tmr_q >= FC_CYC);
    // Short check is active only in the full-current band and not in dead
    // battery or thermal foldback.
    wire short_flt = dn_short_s & therm_full_band & ~die_s &
        ~st_q[1];

    // Current scale shared by the prequal, done and fast-charge targets:
    // full in the normal band, half in the cool band, off elsewhere.
    function [`BCS_SCALE_W-1:0] scale_of;
        input cool;
        input full;
        begin
            if (full)
                scale_of = `BCS_SCALE_FULL;
            else if (cool)
                scale_of = `BCS_SCALE_HALF;
            else
                scale_of = `BCS_SCALE_OFF;
        end
    endfunction

    always @(posedge clk) begin
        if (!rstn) begin
            vin_ok_q <= 1'b0;
            dis_prev_q <= 1'b1;
        end else begin
            dis_prev_q <= dis_s;
            if (!uv_fall_s)
                vin_ok_q <= 1'b0;
            else if (uv_rise_s)
                vin_ok_q <= 1'b1;
            else if (dis_rise)
                vin_ok_q <= 1'b0;
        end
    end

    // One transition per cycle from the registered state.
    always @* begin
        st_d = st_q;
        if (!enable_ok && !st_q[8]) begin
            st_d = `BCS_ST_DISABLED;
        end else begin
            case (st_q)
                `BCS_ST_DISABLED: begin
                    // Entry goes straight to the state for the cell level.
                    if (!vb_dead_s)
                        st_d = `BCS_ST_DEAD;
                    else if (!vb_dup_s)
                        st_d = `BCS_ST_DEAD_PQ;
                    else if (!vb_pq_s)
                        st_d = `BCS_ST_PREQUAL;
                    else
                        st_d = `BCS_ST_FC_CC;
                end
                `BCS_ST_DEAD: begin
                    if (pq_exp)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && vb_dead_s)
                        st_d = `BCS_ST_DEAD_PQ;
                end
                `BCS_ST_DEAD_PQ: begin
                    if (pq_exp || short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && vb_dup_s)
                        st_d = `BCS_ST_PREQUAL;
                end
                `BCS_ST_PREQUAL: begin
                    if (pq_exp || short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && vb_pq_s)
                        st_d = `BCS_ST_FC_CC;
                end
                `BCS_ST_FC_CC: begin
                    if (fc_exp || short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && vb_reg_s)
                        st_d = `BCS_ST_FC_CV;
                end
                `BCS_ST_FC_CV: begin
                    if (fc_exp || short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && i_lo_s)
                        st_d = `BCS_ST_TOPOFF;
                end
                `BCS_ST_TOPOFF: begin
                    if (short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (!suspend && to_tmr_q >= TOPOFF_CYC)
                        st_d = `BCS_ST_DONE;
                    else if (!suspend && i_hi_s)
                        st_d = `BCS_ST_FC_CV;
                end
                `BCS_ST_DONE: begin
                    // An open done pin gives zero done current, so the
                    // fast-charge timer still bounds the stay here.
                    if (fc_exp && dn_open_s)
                        st_d = `BCS_ST_FAULT;
                    else if (short_flt)
                        st_d = `BCS_ST_FAULT;
                    else if (vb_rst_s)
                        st_d = `BCS_ST_FC_CC;
                end
                `BCS_ST_FAULT: begin
                    // Only a disable edge or loss of supply leaves here.
                    if (dis_rise || !vin_ok_q)
                        st_d = `BCS_ST_DISABLED;
                end
                default: st_d = `BCS_ST_DISABLED;
            endcase
        end
    end

    // Timers follow the next state, so a timer starts counting on the edge
    // that enters its state and clears on the edge that leaves it. A cold,
    // hot or overvoltage suspend holds the count and never clears it.
    always @(posedge clk) begin
        if (!rstn) begin
            st_q <= `BCS_ST_DISABLED;
            pq_tmr_q <= {`BCS_TMR_W{1'b0}};
            fc_tmr_q <= {`BCS_TMR_W{1'b0}};
            to_tmr_q <= {`BCS_TMR_W{1'b0}};
            from_done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q[7] && st_d[4])
                from_done_q <= 1'b1;
            else if (!st_d[4] && !st_d[5])
                from_done_q <= 1'b0;
            if (!(st_d[1] | st_d[2] | st_d[3]))
                pq_tmr_q <= {`BCS_TMR_W{1'b0}};
            else if (!suspend && !pq_exp)
                pq_tmr_q <= pq_tmr_q + 1'b1;
            if (!(st_d[4] | st_d[5] | st_d[6] | st_d[7]))
                fc_tmr_q <= {`BCS_TMR_W{1'b0}};
            else if (st_q[7] && st_d[4])
                fc_tmr_q <= {`BCS_TMR_W{1'b0}};
            else if (!suspend && !fc_exp && !st_q[6])
                fc_tmr_q <= fc_tmr_q + 1'b1;
            if (!st_d[6])
                to_tmr_q <= {`BCS_TMR_W{1'b0}};
            else if (!suspend && to_tmr_q < TOPOFF_CYC)
                to_tmr_q <= to_tmr_q + 1'b1;
        end
    end

    // Registered outputs decoded from the current state and the synchronised flags.
    // Decoding the present state rather than the next one keeps every
    // output on a flop with no path from a pin, and lets the state port
    // and the enables change on the same edge.
    always @(posedge clk) begin
        if (!rstn) begin
            linear_en <= 1'b0;
            switcher_en <= 1'b0;
            internal_linear_regulator_en <= 1'b0;
            low_power <= 1'b1;
            soft_start_en <= 1'b0;
            prequal_scale <= `BCS_SCALE_OFF;
            done_scale <= `BCS_SCALE_OFF;
            fast_scale <= `BCS_SCALE_OFF;
            fast_foldback <= 1'b0;
            vreg_reduced <= 1'b0;
            timer_run <= 1'b0;
            state <= `BCS_ST_DISABLED;
        end else begin
            state <= st_q;
            internal_linear_regulator_en <= ~st_q[0];
            low_power <= st_q[0];
            linear_en <= (st_q[1] | st_q[2]) & ~suspend;
            switcher_en <= (st_q[2] | st_q[3] | st_q[4] | st_q[5] |
                st_q[6]) & ~suspend;
            soft_start_en <= ~from_done_q;
            if (dn_open_s) begin
                prequal_scale <= `BCS_SCALE_OFF;
                done_scale <= `BCS_SCALE_OFF;
            end else begin
                prequal_scale <= scale_of(therm_cool_band,
                    therm_full_band);
                done_scale <= scale_of(therm_cool_band,
                    therm_full_band);
            end
            fast_scale <= scale_of(therm_cool_band,
                therm_full_band);
            fast_foldback <= die_s;
            vreg_reduced <= t_warm_s & ~t_hot_s;
            timer_run <= charging & ~suspend & ~tmr_off_s;
        end
    end
endmodule

// ==== bcs_charge_monitor.sv ====
/*
 * Checker for the charge state sequencer: state and output relations.
 * Assumes the enables change on the same edge as the state port.
 */
`timescale 1ns/10ps
`include "bcs_defs.vh"
module bcs_charge_monitor (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Watched ports
    input wire charge_disable_in,
    input wire linear_en,
    input wire switcher_en,
    input wire internal_linear_regulator_en,
    input wire low_power,
    input wire soft_start_en,
    input wire [`BCS_ST_W-1:0] state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    disable_hold_a: assert property (
        charge_disable_in [*4] |=> state == `BCS_ST_DISABLED)
        else $error("state left disabled while disable held");
    disabled_off_a: assert property (
        state == `BCS_ST_DISABLED |-> !switcher_en && !linear_en
        && !internal_linear_regulator_en && low_power)
        else $error("charger not shut down while disabled");
    dead_linear_a: assert property (
        state == `BCS_ST_DEAD |-> !switcher_en)
        else $error("switcher on in dead battery state");
    prequal_sw_a: assert property (
        state == `BCS_ST_PREQUAL |-> !linear_en)
        else $error("linear charger on in prequal");
    fault_off_a: assert property (
        state == `BCS_ST_FAULT ##1 state == `BCS_ST_FAULT
        |-> !switcher_en && !linear_en)
        else $error("charger on in timer fault");
    fault_exit_a: assert property (
        $past(state) == `BCS_ST_FAULT |-> state == `BCS_ST_FAULT
        || state == `BCS_ST_DISABLED)
        else $error("timer fault left to a charging state");
    cc_exit_a: assert property (
        $past(state) == `BCS_ST_FC_CC && state != `BCS_ST_FC_CC
        |-> state inside {`BCS_ST_FC_CV, `BCS_ST_FAULT,
        `BCS_ST_DISABLED})
        else $error("bad exit from constant current");
    restart_soft_a: assert property (
        $past(state) == `BCS_ST_DONE && state == `BCS_ST_FC_CC
        |=> !soft_start_en)
        else $error("soft start on restart from done");
    one_hot_a: assert property (
        $onehot(state))
        else $error("state not one-hot");

    cover property (state == `BCS_ST_DONE);
    cover property (state == `BCS_ST_FAULT);
    cover property ($past(state) == `BCS_ST_DONE
        && state == `BCS_ST_FC_CC);
endmodule

bind bcs_charge_ctrl bcs_charge_monitor mon (.clk(clk), .rstn(rstn),
    .charge_disable_in(charge_disable_in), .linear_en(linear_en),
    .switcher_en(switcher_en), .low_power(low_power),
    .internal_linear_regulator_en(internal_linear_regulator_en),
    .soft_start_en(soft_start_en), .state(state));

// ==== bcs_batt_model.sv ====
/*
 * Behavioural single cell: charge rises while either charger is on.
 * Assumes the bench sets charge and hold directly between scenarios.
 */
`timescale 1ns/10ps
module bcs_batt_model (
    // Clock
    input wire clk,
    // Charger enables
    input wire linear_en,
    input wire switcher_en,
    // Comparator flags
    output wire vbat_above_dead_batt,
    output wire vbat_above_dead_batt_upper,
    output wire vbat_above_prequal_upper,
    output wire vbat_at_regulation,
    output wire vbat_below_restart,
    output wire ibat_below_done,
    output wire ibat_above_done_margin
);
    integer charge = 0;
    reg hold = 1'b0;

    // Voltage clamps at regulation; charge above it models current taper.
    assign vbat_above_dead_batt = charge >= 8'h0A;
    assign vbat_above_dead_batt_upper = charge >= 8'h14;
    assign vbat_above_prequal_upper = charge >= 8'h1E;
    assign vbat_at_regulation = charge >= 8'h28;
    assign vbat_below_restart = charge < 8'h2A;
    assign ibat_below_done = charge >= 8'h32;
    assign ibat_above_done_margin = charge < 8'h30;

    always @(posedge clk) begin
        if (!hold && (linear_en || switcher_en) && charge < 8'h64) begin
            charge <= charge + 1;
        end
    end
endmodule

// ==== battery_charge_state_controller_test.sv ====
/*
 * Self-checking bench for the charge state sequencer with a cell model.
 * Assumes short timer parameters so every limit is reached quickly.
 */
`timescale 1ns/10ps
`include "bcs_defs.vh"
module battery_charge_state_controller_test;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg dis = 1'b1;
    reg uv_r = 1'b0;
    reg uv_f = 1'b1;
    reg cold = 1'b1;
    reg cool = 1'b1;
    reg warm = 1'b0;
    reg hot = 1'b0;
    reg die = 1'b0;
    reg shorted = 1'b0;
    reg ovlo = 1'b0;
    reg tmr_off = 1'b0;
    reg dn_open = 1'b0;
    wire lin, sw, reg_en, lowp, ss, fold, vred, trun;
    wire [1:0] pq_s, dn_s, fc_s;
    wire [8:0] state;
    wire f_dead, f_up, f_pq, f_reg, f_rst, f_dn, f_mg;
    integer num_errors = 0;
    integer check_count = 0;

    bcs_charge_ctrl #(.PQ_CYC(42'h3C), .FC_CYC(42'h50),
        .TOPOFF_CYC(42'h0A)) DUT (.clk(clk), .rstn(rstn),
        .charge_disable_in(dis), .vin_above_uvlo_rising(uv_r),
        .vin_above_uvlo_falling(uv_f), .vin_over_ovlo(ovlo),
        .timer_disable(tmr_off), .vbat_above_dead_batt(f_dead),
        .vbat_above_dead_batt_upper(f_up),
        .vbat_above_prequal_upper(f_pq), .vbat_at_regulation(f_reg),
        .vbat_below_restart(f_rst), .ibat_below_done(f_dn),
        .ibat_above_done_margin(f_mg), .therm_above_cold(cold),
        .therm_above_cool(cool), .therm_above_warm(warm),
        .therm_above_hot(hot), .die_above_temp_reg(die),
        .done_pin_shorted(shorted), .done_pin_open(dn_open),
        .linear_en(lin), .switcher_en(sw),
        .internal_linear_regulator_en(reg_en), .low_power(lowp),
        .soft_start_en(ss), .prequal_scale(pq_s), .done_scale(dn_s),
        .fast_scale(fc_s), .fast_foldback(fold), .vreg_reduced(vred),
        .timer_run(trun), .state(state));

    bcs_batt_model batt (.clk(clk), .linear_en(lin), .switcher_en(sw),
        .vbat_above_dead_batt(f_dead), .vbat_above_dead_batt_upper(f_up),
        .vbat_above_prequal_upper(f_pq), .vbat_at_regulation(f_reg),
        .vbat_below_restart(f_rst), .ibat_below_done(f_dn),
        .ibat_above_done_margin(f_mg));

    initial begin
        forever #2 clk = ~clk;
    end

    task chk(input [63:0] name, input [8:0] seen, input [8:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask

    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait; a miss ends the run at once.
    task wait_st(input [8:0] s);
        integer i;
        begin
            i = 0;
            while (state !== s && i < 300) begin
                cyc(1);
                i = i + 1;
            end
            chk("state", state, s);
            if (state !== s) conclude;
        end
    endtask

    task start(input integer c);
        begin
            dis = 1'b1;
            cyc(6);
            batt.charge = c;
            dis = 1'b0;
        end
    endtask

    task t_startup;
        begin
            chk("state", state, `BCS_ST_DISABLED);
            chk("lowp", lowp, 1'b1);
            chk("reg_en", reg_en, 1'b0);
            dis = 1'b0;
            cyc(10);
            chk("state", state, `BCS_ST_DISABLED);
            uv_r = 1'b1;
            wait_st(`BCS_ST_DEAD);
            cyc(2);
            chk("lin", lin, 1'b1);
            chk("sw", sw, 1'b0);
        end
    endtask

    task t_full;
        begin
            wait_st(`BCS_ST_DEAD_PQ);
            cyc(2);
            chk("sw", {lin, sw}, 2'h3);
            wait_st(`BCS_ST_PREQUAL);
            cyc(2);
            chk("sw", {lin, sw}, 2'h1);
            chk("pq_s", pq_s, `BCS_SCALE_FULL);
            wait_st(`BCS_ST_FC_CC);
            wait_st(`BCS_ST_FC_CV);
            wait_st(`BCS_ST_TOPOFF);
            cyc(6);
            chk("state", state, `BCS_ST_TOPOFF);
            chk("sw", sw, 1'b1);
            wait_st(`BCS_ST_DONE);
            cyc(2);
            chk("sw", sw, 1'b0);
            batt.charge = 8'h29;
            wait_st(`BCS_ST_FC_CC);
            cyc(2);
            chk("ss", ss, 1'b0);
            wait_st(`BCS_ST_TOPOFF);
            batt.charge = 8'h2D;
            wait_st(`BCS_ST_FC_CV);
        end
    endtask

    task t_fault;
        begin
            start(8'h14);
            batt.hold = 1'b1;
            wait_st(`BCS_ST_PREQUAL);
            wait_st(`BCS_ST_FAULT);
            cyc(20);
            chk("state", state, `BCS_ST_FAULT);
            chk("sw", sw, 1'b0);
        end
    endtask

    task t_temp;
        begin
            start(8'h1E);
            wait_st(`BCS_ST_FC_CC);
            cool = 1'b0;
            cyc(5);
            chk("fc_s", fc_s, `BCS_SCALE_HALF);
            chk("pq_s", pq_s, `BCS_SCALE_HALF);
            chk("dn_s", dn_s, `BCS_SCALE_HALF);
            cool = 1'b1;
            die = 1'b1;
            cyc(5);
            chk("fold", fold, 1'b1);
            die = 1'b0;
            warm = 1'b1;
            cyc(5);
            chk("vred", vred, 1'b1);
            warm = 1'b0;
            cold = 1'b0;
            cyc(6);
            chk("sw", sw, 1'b0);
            chk("state", state, `BCS_ST_FC_CC);
            chk("trun", trun, 1'b0);
            cold = 1'b1;
            cyc(5);
            chk("sw", sw, 1'b1);
            chk("trun", trun, 1'b1);
            dn_open = 1'b1;
            cyc(5);
            chk("pq_s", pq_s, `BCS_SCALE_OFF);
            chk("dn_s", dn_s, `BCS_SCALE_OFF);
            dn_open = 1'b0;
            ovlo = 1'b1;
            cyc(6);
            chk("sw", sw, 1'b0);
            chk("trun", trun, 1'b0);
            chk("state", state, `BCS_ST_FC_CC);
            ovlo = 1'b0;
            cyc(5);
            chk("sw", sw, 1'b1);
            shorted = 1'b1;
            wait_st(`BCS_ST_FAULT);
            shorted = 1'b0;
            uv_r = 1'b0;
            uv_f = 1'b0;
            cyc(6);
            chk("state", state, `BCS_ST_DISABLED);
            uv_r = 1'b1;
            uv_f = 1'b1;
            wait_st(`BCS_ST_FC_CC);
            tmr_off = 1'b1;
            cyc(100);
            chk("state", state, `BCS_ST_FC_CC);
            chk("trun", trun, 1'b0);
            tmr_off = 1'b0;
            wait_st(`BCS_ST_FAULT);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        cyc(3);
        t_startup;
        t_full;
        t_fault;
        t_temp;
        conclude;
    end
endmodule
